// ===== hw/mlm_map.vh
// address map, instruction fields and timing constants of the load/multiply core
`ifndef MLM_MAP_VH
`define MLM_MAP_VH
// apb byte addresses
`define MLM_A_INSTR 12'h000
`define MLM_A_STATUS 12'h004
`define MLM_A_BASE 12'h008
`define MLM_A_IMM 12'h00c
`define MLM_A_JT1 12'h010
`define MLM_A_JT2 12'h014
`define MLM_A_PLO 12'h018
`define MLM_A_PHI 12'h01c
`define MLM_A_CORE 12'h020
`define MLM_A_TC 12'h040
`define MLM_A_CNT 12'h050
`define MLM_A_RAM 12'h100
// status bits
`define MLM_ST_BUSY 0
`define MLM_ST_OVF 1
`define MLM_ST_LOSS 2
`define MLM_ST_DONE 3
`define MLM_ST_OUT1 4
`define MLM_ST_OUT2 5
// opcode patterns
`define MLM_OP_CNT 2'b01
`define MLM_OP_IMM 5'b00111
`define MLM_LO_IMMH 2'b11
`define MLM_LO_IMML 2'b10
`define MLM_OP_JT1 4'b1000
`define MLM_OP_JT2 4'b1001
`define MLM_LO_JT 2'b00
`define MLM_OP_LOAD 2'b10
`define MLM_LO_LOAD 2'b10
`define MLM_OP_MUL 10'b0010110110
// shortcut codes
`define MLM_SC_OFF 2'b01
`define MLM_SC_ON 2'b10
`define MLM_SC_TGL 2'b11
// timing
`define MLM_MUL_CYCLES 5'd17
`define MLM_RESET_W16 16'h0000
`endif

// ===== hw/mlm_core.v
// execution of counter, immediate, jump, ram-load and multiply instructions behind apb
// How it works
// - count-from-ram writes the addressed data ram word into a terminal-count register
// - two-bit selector picks terminal-count register one to four
// - clear bit set zeroes the chosen counter, else only terminal count changes
// - shortcut codes: keep, disable, enable, invert each output
// - count-from-ram index bit adds the address base to the address field
// - upper-immediate load writes its byte into immediate bits 15 to 8
// - upper clear bit set zeroes immediate bits 15 to 8
// - lower-immediate load writes its byte into immediate bits 7 to 0
// - lower clear bit set zeroes immediate bits 7 to 0
// - first jump load puts ten-bit literal into first jump register
// - second jump load puts ten-bit literal into second jump register
// - ram-load copies the addressed data ram word into a core register
// - ram-load index bit selects base plus field, else field alone
// - multiply puts the upper product half into the high register
// - multiply takes seventeen clock cycles from issue to result
// - multiply updates overflow, precision-loss and complete flags
// - low product register holds the lower sixteen bits
`timescale 1ns/100ps
`default_nettype none
`include "mlm_map.vh"
module mlm_core #(
    parameter RAM_WORDS = 64,
    parameter CORE_REGS = 8
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    output wire first_output_shortcut,
    output wire second_output_shortcut,
    output wire busy
);
    reg [15:0] ram_q [0:RAM_WORDS-1];
    reg [15:0] core_q [0:CORE_REGS-1];
    reg [15:0] tc_q [0:3];
    reg [15:0] cnt_q [0:3];
    reg [5:0] base_q;
    reg [15:0] immediate_register_q;
    reg [15:0] jump_target_one_q;
    reg [15:0] jump_target_two_q;
    reg [15:0] product_low_half_q;
    reg [15:0] product_high_half_q;
    reg shift_overflow_flag_q;
    reg shift_precision_lost_flag_q;
    reg multiply_finished_flag_q;
    reg out1_q;
    reg out2_q;
    reg [15:0] instr_q;
    reg exec_q;
    reg [4:0] mul_cnt_q;
    reg [31:0] mul_a_q;
    reg [15:0] mul_b_q;
    reg [31:0] mul_acc_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;
    reg err_d;
    integer i;

    // effective data ram address, shared by both ram-reading instructions
    function [5:0] eff_addr;
        input ofs;
        input [5:0] field;
        input [5:0] base;
        begin
            if (ofs) begin
                eff_addr = base + field;
            end else begin
                eff_addr = field;
            end
        end
    endfunction

    function shortcut;
        input [1:0] code;
        input cur;
        begin
            case (code)
                `MLM_SC_OFF: shortcut = 1'b0;
                `MLM_SC_ON: shortcut = 1'b1;
                `MLM_SC_TGL: shortcut = ~cur;
                default: shortcut = cur;
            endcase
        end
    endfunction

    // address window decode, shared by the read mux and the write strobes
    function in_win;
        input [11:0] addr;
        input [11:0] lo;
        input [11:0] hi;
        begin
            in_win = (addr >= lo) && (addr < hi);
        end
    endfunction

    wire access = psel & penable;
    wire wr_en = access & pwrite;
    wire mul_busy = (mul_cnt_q != 5'd0);
    assign busy = exec_q | mul_busy;
    // no wait states: every register answers in its first access cycle
    assign pready = 1'b1;
    assign prdata = rdata_q;
    assign first_output_shortcut = out1_q;
    assign second_output_shortcut = out2_q;

    // counter window is as wide as the terminal-count window
    localparam [11:0] CNT_END = `MLM_A_CNT + (`MLM_A_CNT - `MLM_A_TC);
    // write strobes; a refused access never writes, misaligned ones included
    // writes to read-only words are dropped without an error
    wire wr_ok = wr_en & ~err_d;
    wire wr_ram = wr_ok & (paddr >= `MLM_A_RAM);
    wire wr_core = wr_ok & in_win(paddr, `MLM_A_CORE, `MLM_A_TC);
    wire wr_tc = wr_ok & in_win(paddr, `MLM_A_TC, `MLM_A_CNT);
    wire wr_imm = wr_ok & (paddr == `MLM_A_IMM);
    wire wr_jt1 = wr_ok & (paddr == `MLM_A_JT1);
    wire wr_jt2 = wr_ok & (paddr == `MLM_A_JT2);
    wire wr_base = wr_ok & (paddr == `MLM_A_BASE);

    // instruction decode, valid in the execute cycle only
    wire dec_cnt = exec_q & (instr_q[15:14] == `MLM_OP_CNT);
    wire dec_immh = exec_q & (instr_q[15:11] == `MLM_OP_IMM) & (instr_q[1:0] == `MLM_LO_IMMH);
    wire dec_imml = exec_q & (instr_q[15:11] == `MLM_OP_IMM) & (instr_q[1:0] == `MLM_LO_IMML);
    wire dec_jt1 = exec_q & (instr_q[15:12] == `MLM_OP_JT1) & (instr_q[1:0] == `MLM_LO_JT);
    wire dec_jt2 = exec_q & (instr_q[15:12] == `MLM_OP_JT2) & (instr_q[1:0] == `MLM_LO_JT);
    wire dec_load = exec_q & (instr_q[15:14] == `MLM_OP_LOAD) & (instr_q[1:0] == `MLM_LO_LOAD);
    wire dec_mul = exec_q & (instr_q[15:6] == `MLM_OP_MUL);

    wire [5:0] cnt_ea = eff_addr(instr_q[13], instr_q[5:0], base_q);
    wire [5:0] load_ea = eff_addr(instr_q[2], instr_q[13:8], base_q);
    wire [1:0] tc_sel = instr_q[7:6];
    wire [2:0] load_dst = instr_q[5:3];
    wire [7:0] byte_literal = instr_q[9:2];
    wire [9:0] ten_bit_literal = instr_q[11:2];
    wire [15:0] first_operand_reg = core_q[instr_q[2:0]];
    wire [15:0] second_operand_reg = core_q[instr_q[5:3]];
    wire [31:0] mul_acc_d = mul_acc_q + (mul_b_q[0] ? mul_a_q : 32'h0000_0000);
    wire instr_wr = wr_en & (paddr == `MLM_A_INSTR) & ~busy;

    // apb read mux and error decode
    always @* begin
        rdata_d = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr[1:0] != 2'b00) begin
            err_d = 1'b1;
        end else if (paddr >= `MLM_A_RAM) begin
            if (paddr[11:2] < (`MLM_A_RAM >> 2) + RAM_WORDS) begin
                rdata_d = {16'h0000, ram_q[paddr[7:2]]};
            end else begin
                err_d = 1'b1;
            end
        end else if (paddr == `MLM_A_INSTR) begin
            rdata_d = {16'h0000, instr_q};
            err_d = pwrite & busy;
        end else if (paddr == `MLM_A_STATUS) begin
            rdata_d = {26'h000_0000, out2_q, out1_q, multiply_finished_flag_q,
                shift_precision_lost_flag_q, shift_overflow_flag_q, busy};
        end else if (paddr == `MLM_A_BASE) begin
            rdata_d = {26'h000_0000, base_q};
        end else if (paddr == `MLM_A_IMM) begin
            rdata_d = {16'h0000, immediate_register_q};
        end else if (paddr == `MLM_A_JT1) begin
            rdata_d = {16'h0000, jump_target_one_q};
        end else if (paddr == `MLM_A_JT2) begin
            rdata_d = {16'h0000, jump_target_two_q};
        end else if (paddr == `MLM_A_PLO) begin
            rdata_d = {16'h0000, product_low_half_q};
        end else if (paddr == `MLM_A_PHI) begin
            rdata_d = {16'h0000, product_high_half_q};
        end else if (in_win(paddr, `MLM_A_CORE, `MLM_A_TC)) begin
            rdata_d = {16'h0000, core_q[paddr[4:2]]};
        end else if (in_win(paddr, `MLM_A_TC, `MLM_A_CNT)) begin
            rdata_d = {16'h0000, tc_q[paddr[3:2]]};
        end else if (in_win(paddr, `MLM_A_CNT, CNT_END)) begin
            rdata_d = {16'h0000, cnt_q[paddr[3:2]]};
        end else begin
            err_d = 1'b1;
        end
    end

    // error answer only in the access phase; reads register the data on the setup cycle
    assign pslverr = access & err_d;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_q <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            rdata_q <= rdata_d;
        end
    end

    // instruction issue: written word executes on the following edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            instr_q <= `MLM_RESET_W16;
            exec_q <= 1'b0;
        end else begin
            exec_q <= instr_wr;
            if (instr_wr) begin
                instr_q <= pwdata[15:0];
            end
        end
    end

    // data ram: software writes only, instructions read it combinationally
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < RAM_WORDS; i = i + 1) begin
                ram_q[i] <= `MLM_RESET_W16;
            end
        end else if (wr_ram) begin
            ram_q[paddr[7:2]] <= pwdata[15:0];
        end
    end

    // core register set; an apb write never meets an execute cycle, since issue needs two edges
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < CORE_REGS; i = i + 1) begin
                core_q[i] <= `MLM_RESET_W16;
            end
        end else if (dec_load) begin
            core_q[load_dst] <= ram_q[load_ea];
        end else if (wr_core) begin
            core_q[paddr[4:2]] <= pwdata[15:0];
        end
    end

    // terminal counts, counters and output shortcuts
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 4; i = i + 1) begin
                tc_q[i] <= `MLM_RESET_W16;
                cnt_q[i] <= `MLM_RESET_W16;
            end
            out1_q <= 1'b0;
            out2_q <= 1'b0;
        end else begin
            // free-running up counters that wrap when they reach their terminal count
            for (i = 0; i < 4; i = i + 1) begin
                if (cnt_q[i] >= tc_q[i]) begin
                    cnt_q[i] <= `MLM_RESET_W16;
                end else begin
                    cnt_q[i] <= cnt_q[i] + 16'h0001;
                end
            end
            if (dec_cnt) begin
                tc_q[tc_sel] <= ram_q[cnt_ea];
                if (instr_q[12]) begin
                    cnt_q[tc_sel] <= `MLM_RESET_W16;
                end
                out1_q <= shortcut(instr_q[11:10], out1_q);
                out2_q <= shortcut(instr_q[9:8], out2_q);
            end else if (wr_tc) begin
                tc_q[paddr[3:2]] <= pwdata[15:0];
            end
        end
    end

    // immediate, jump and base registers
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            immediate_register_q <= `MLM_RESET_W16;
            jump_target_one_q <= `MLM_RESET_W16;
            jump_target_two_q <= `MLM_RESET_W16;
            base_q <= 6'h00;
        end else begin
            if (dec_immh) begin
                if (instr_q[10]) begin
                    immediate_register_q[15:8] <= 8'h00;
                end else begin
                    immediate_register_q[15:8] <= byte_literal;
                end
            end else if (dec_imml) begin
                if (instr_q[10]) begin
                    immediate_register_q[7:0] <= 8'h00;
                end else begin
                    immediate_register_q[7:0] <= byte_literal;
                end
            end else if (wr_imm) begin
                immediate_register_q <= pwdata[15:0];
            end
            if (dec_jt1) begin
                jump_target_one_q <= {6'h00, ten_bit_literal};
            end else if (wr_jt1) begin
                jump_target_one_q <= pwdata[15:0];
            end
            if (dec_jt2) begin
                jump_target_two_q <= {6'h00, ten_bit_literal};
            end else if (wr_jt2) begin
                jump_target_two_q <= pwdata[15:0];
            end
            if (wr_base) begin
                base_q <= pwdata[5:0];
            end
        end
    end

    // shift-and-add multiply: issue cycle plus sixteen steps, one bit per step
    // slower than a single-cycle array but keeps the multiplier to one adder
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mul_cnt_q <= 5'd0;
            mul_a_q <= 32'h0000_0000;
            mul_b_q <= `MLM_RESET_W16;
            mul_acc_q <= 32'h0000_0000;
            product_low_half_q <= `MLM_RESET_W16;
            product_high_half_q <= `MLM_RESET_W16;
            shift_overflow_flag_q <= 1'b0;
            shift_precision_lost_flag_q <= 1'b0;
            multiply_finished_flag_q <= 1'b0;
        end else if (dec_mul) begin
            mul_cnt_q <= `MLM_MUL_CYCLES - 5'd1;
            mul_a_q <= {16'h0000, first_operand_reg};
            mul_b_q <= second_operand_reg;
            mul_acc_q <= 32'h0000_0000;
            multiply_finished_flag_q <= 1'b0;
        end else if (mul_busy) begin
            mul_cnt_q <= mul_cnt_q - 5'd1;
            mul_a_q <= {mul_a_q[30:0], 1'b0};
            mul_b_q <= {1'b0, mul_b_q[15:1]};
            mul_acc_q <= mul_acc_d;
            if (mul_cnt_q == 5'd1) begin
                product_high_half_q <= mul_acc_d[31:16];
                product_low_half_q <= mul_acc_d[15:0];
                // a plain product cannot overflow 32 bits nor drop bits
                shift_overflow_flag_q <= 1'b0;
                shift_precision_lost_flag_q <= 1'b0;
                multiply_finished_flag_q <= 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ===== verif/mlm_core_sva.sv
// port-level assertions for the load/multiply core
`timescale 1ns/100ps
`default_nettype none
`include "mlm_map.vh"
module mlm_core_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic first_output_shortcut,
    input wire logic second_output_shortcut,
    input wire logic busy
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire logic acc = psel && penable && pwrite && paddr == `MLM_A_INSTR;
    wire logic go = acc && !pslverr;
    wire logic is_mul = go && pwdata[15:6] == `MLM_OP_MUL;
    wire logic is_cnt = go && pwdata[15:14] == `MLM_OP_CNT;
    wire logic [1:0] sc1 = pwdata[11:10];
    wire logic [1:0] sc2 = pwdata[9:8];
    a_mul_busy_span: assert property (is_mul |-> ##17 busy ##1 !busy)
        else $error("multiply busy span wrong");
    a_plain_busy_one: assert property (go && !is_mul |=> busy ##1 !busy)
        else $error("plain instruction busy span wrong");
    a_busy_refuses: assert property (acc && busy |-> pslverr)
        else $error("instruction accepted while busy");
    a_sc1_cause: assert property ($changed(first_output_shortcut) |-> $past(busy))
        else $error("first output changed without an instruction");
    a_sc2_cause: assert property ($changed(second_output_shortcut) |-> $past(busy))
        else $error("second output changed without an instruction");
    a_sc1_on: assert property (is_cnt && sc1 == `MLM_SC_ON
        |-> ##2 first_output_shortcut)
        else $error("first output not enabled");
    a_sc1_off: assert property (is_cnt && sc1 == `MLM_SC_OFF
        |-> ##2 !first_output_shortcut)
        else $error("first output not disabled");
    a_sc2_toggle: assert property (is_cnt && sc2 == `MLM_SC_TGL
        |-> ##2 second_output_shortcut != $past(second_output_shortcut))
        else $error("second output not inverted");
    a_sc2_keep: assert property (is_cnt && sc2 == 2'h0
        |-> ##2 $stable(second_output_shortcut))
        else $error("second output not kept");
    c_mul: cover property (is_mul);
    c_cnt_toggle: cover property (is_cnt && sc2 == `MLM_SC_TGL);
    c_refused: cover property (acc && busy);
endmodule
`default_nettype wire

// ===== verif/mlm_core_tb.sv
// self-checking bench for the load/multiply core over apb
`timescale 1ns/100ps
`default_nettype none
`include "mlm_map.vh"
module mlm_core_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    wire logic [31:0] prdata;
    wire logic pready;
    wire logic pslverr;
    wire logic o1;
    wire logic o2;
    wire logic busy;
    logic [31:0] rv;
    logic ev;
    logic rdy;
    logic [1:0] c1;
    logic [1:0] c2;
    logic x;
    logic clr;
    logic x1 = 1'b0;
    logic x2 = 1'b0;
    int fail_count = 0;
    int samples_checked = 0;
    always #5 pclk = ~pclk;
    mlm_core dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .first_output_shortcut(o1), .second_output_shortcut(o2),
        .busy(busy));
    task automatic stop_test;
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            fail_count++;
            $display("Error at %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // request stands until pready is seen high at a rising edge; the answer is taken there
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            rdy = pready;
            rv = prdata;
            ev = pslverr;
            k++;
        end while (rdy !== 1'b1 && k < 20);
        if (rdy !== 1'b1) begin
            fail_count++;
            stop_test;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rv, e);
    endtask
    task automatic idle;
        int k;
        k = 0;
        do begin
            @(negedge pclk);
            k++;
        end while (busy !== 1'b0 && k < 40);
        if (busy !== 1'b0) begin
            fail_count++;
            stop_test;
        end
        @(posedge pclk);
    endtask
    task automatic ins(input logic [15:0] d);
        apb(1'b1, `MLM_A_INSTR, {16'h0, d});
        idle;
    endtask
    function automatic logic sc(input logic [1:0] c, input logic v);
        return c == 2'h1 ? 1'b0 : c == 2'h2 ? 1'b1 : c == 2'h3 ? !v : v;
    endfunction
    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        stop_test;
    end
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(`MLM_A_STATUS, 32'h0);
        ins({`MLM_OP_IMM, 1'b0, 8'ha5, `MLM_LO_IMMH});
        ins({`MLM_OP_IMM, 1'b0, 8'h3c, `MLM_LO_IMML});
        rd(`MLM_A_IMM, 32'ha53c);
        ins({`MLM_OP_IMM, 1'b1, 8'hff, `MLM_LO_IMMH});
        rd(`MLM_A_IMM, 32'h003c);
        ins({`MLM_OP_IMM, 1'b1, 8'hff, `MLM_LO_IMML});
        rd(`MLM_A_IMM, 32'h0);
        ins({`MLM_OP_JT1, 10'h3ff, `MLM_LO_JT});
        ins({`MLM_OP_JT2, 10'h155, `MLM_LO_JT});
        rd(`MLM_A_JT1, 32'h3ff);
        rd(`MLM_A_JT2, 32'h155);
        apb(1'b1, `MLM_A_RAM + 12'h014, 32'h1234);
        apb(1'b1, `MLM_A_RAM + 12'h004, 32'hbeef);
        apb(1'b1, `MLM_A_BASE, 32'h3c);
        // indexed field 5 from base 60 wraps round to word 1
        ins({`MLM_OP_LOAD, 6'h05, 2'h0, 3'h3, 1'b0, `MLM_LO_LOAD});
        ins({`MLM_OP_LOAD, 6'h05, 2'h0, 3'h4, 1'b1, `MLM_LO_LOAD});
        rd(`MLM_A_CORE + 12'h00c, 32'h1234);
        rd(`MLM_A_CORE + 12'h010, 32'hbeef);
        rd(12'h060, 32'h0);
        chk({31'h0, ev}, 32'h1);
        for (int s = 0; s < 4; s++) begin
            apb(1'b1, `MLM_A_RAM + 12'h020 + 12'(4 * s), 32'hff00 + 32'(s));
        end
        for (int p = 0; p < 2; p++) begin
            for (int s = 0; s < 4; s++) begin
                c1 = p ? 2'h0 : 2'(s);
                c2 = p ? 2'h0 : 2'(3 - s);
                x = (p == 0 && s == 3);
                clr = p && s[0];
                ins({`MLM_OP_CNT, x, clr, c1, c2, 2'(s), x ? 6'(s + 12) : 6'(s + 8)});
                x1 = sc(c1, x1);
                x2 = sc(c2, x2);
                chk({30'h0, o2, o1}, {30'h0, x2, x1});
                rd(`MLM_A_TC + 12'(4 * s), 32'hff00 + 32'(s));
                if (p) begin
                    apb(1'b0, `MLM_A_CNT + 12'(4 * s), 32'h0);
                    chk(32'(rv[15:0] < 16'h0010), 32'(clr));
                end
            end
            repeat (60) @(posedge pclk);
        end
        apb(1'b1, `MLM_A_CORE + 12'h004, 32'hfffe);
        apb(1'b1, `MLM_A_CORE + 12'h008, 32'h8003);
        apb(1'b1, `MLM_A_INSTR, {16'h0, `MLM_OP_MUL, 3'h2, 3'h1});
        apb(1'b1, `MLM_A_INSTR, 32'h1234);
        chk({31'h0, ev}, 32'h1);
        rd(`MLM_A_STATUS, {26'h0, x2, x1, 4'h1});
        rd(`MLM_A_PLO, 32'h0);
        idle;
        rd(`MLM_A_PLO, 32'hfffa);
        rd(`MLM_A_PHI, 32'h8001);
        rd(`MLM_A_STATUS, {26'h0, x2, x1, 4'h8});
        stop_test;
    end
endmodule
bind mlm_core mlm_core_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .first_output_shortcut(first_output_shortcut),
    .second_output_shortcut(second_output_shortcut), .busy(busy));
`default_nettype wire
